// File: dv/nvm_program_erase_control_test.sv
`timescale 1ns/100ps
module nvm_program_erase_control_test;
  import nvmpe_pkg::*;
  logic       clk, rst_n, io_wr, io_rd, data_wr, mem_rd, mem_wr, cpu_wait, irq;
  logic       arr_write, arr_page_erase, arr_bulk_erase, arr_info, clk_en;
  logic [7:0] io_addr, io_wdata, io_rdata, data_wdata, block_protect, arr_wdata, v;
  logic [7:0] flash_divider;
  logic [6:0] arr_page, arr_column;
  logic [2:0] arr_row;
  int         err_count, n_checks;
  nvmpe_ctrl nvmpe_ctrl_inst (.clk, .rst_n, .clk_en, .io_addr, .io_wdata, .io_wr,
    .io_rd, .io_rdata, .data_wr, .data_wdata, .mem_rd, .mem_wr, .flash_divider,
    .block_protect, .cpu_wait, .irq, .arr_write, .arr_page_erase, .arr_bulk_erase,
    .arr_info, .arr_page, .arr_row, .arr_column, .arr_wdata);
  nvmpe_flash_model nvmpe_flash_model_inst (.clk, .arr_write, .arr_page_erase,
    .arr_bulk_erase, .arr_info, .arr_page, .arr_row, .arr_column, .arr_wdata);
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(); @(posedge clk); #1; endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (e !== g)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a; io_wdata = d; io_wr = 1; cyc(); io_wr = 0; cyc();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    io_addr = a; io_rd = 1; cyc(); io_rd = 0; cyc(); d = io_rdata;
  endtask
  task automatic bw(input logic [7:0] d);
    data_wdata = d; data_wr = 1; cyc(); data_wr = 0; cyc();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, v); chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 20000; n++)
    begin
      rd(8'hff, v);
      if (v === 8'h00) break;
    end
    if (n == 20000)
    begin
      err_count++;
      final_report();
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {rst_n, io_wr, io_rd, data_wr, mem_rd, mem_wr} = 0;
    {io_addr, io_wdata, data_wdata} = 0;
    clk_en = 1; flash_divider = 8'h01;
    block_protect = 8'hff;
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    cyc();
    for (int i = 0; i < 6; i++) rdc(8'(8'hfa + i), 8'h00);
    $display("end reset values");
    wr(8'hfc, 8'hff); wr(8'hfd, 8'hff); wr(8'hfe, 8'hff); wr(8'hff, 8'hf8);
    rdc(8'hfc, 8'hff); rdc(8'hfd, 8'h07); rdc(8'hfe, 8'h7f); rdc(8'hff, 8'h00);
    clk_en = 0; wr(8'hfc, 8'h55); clk_en = 1; rdc(8'hfc, 8'hff);
    $display("end register access");
    block_protect = 8'h00;
    wr(8'hfc, 8'h12); wr(8'hfd, 8'h03); wr(8'hfe, 8'h05); bw(8'ha5);
    chk("byte", 8'ha5, nvmpe_flash_model_inst.peek({1'b0, 7'h12, 3'h3, 7'h05}));
    block_protect = 8'h02;
    wr(8'hfe, 8'h06); bw(8'h5a);
    chk("blocked", 8'hff, nvmpe_flash_model_inst.peek({1'b0, 7'h12, 3'h3, 7'h06}));
    rdc(8'hfb, 8'h08); rdc(8'hfb, 8'h00);
    block_protect = 8'hff;
    wr(8'hfc, 8'h80); wr(8'hfd, 8'h01); wr(8'hfe, 8'h02); bw(8'h3c);
    chk("info", 8'h3c, nvmpe_flash_model_inst.peek({1'b1, 7'h00, 3'h1, 7'h02}));
    $display("end byte writes");
    wr(8'hfb, 8'hc0); rdc(8'hfb, 8'hc0);
    wr(8'hfc, 8'h12);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'hff, 8'(1 << i)); repeat (3) cyc();
      chk("irq", 8'h01, {7'h00, irq});
      rdc(8'hfb, 8'(8'hc0 | (1 << i))); rdc(8'hff, 8'h00);
      chk("irq clear", 8'h00, {7'h00, irq});
    end
    $display("end refusals");
    block_protect = 8'h00;
    wr(8'hfc, 8'h12); wr(8'hff, 8'h02);
    mem_rd = 1; repeat (2) cyc(); mem_rd = 0;
    chk("erase wait", 8'h01, {7'h00, cpu_wait});
    wait_idle();
    chk("done irq", 8'h01, {7'h00, irq});
    rdc(8'hfb, 8'he0);
    chk("erased", 8'hff, nvmpe_flash_model_inst.peek({1'b0, 7'h12, 3'h3, 7'h05}));
    $display("end page erase");
    wr(8'hfc, 8'h01); wr(8'hfd, 8'h00); wr(8'hfe, 8'h7e); wr(8'hff, 8'h04); bw(8'h11);
    mem_rd = 1; repeat (2) cyc(); mem_rd = 0;
    chk("row wait", 8'h01, {7'h00, cpu_wait});
    bw(8'h22); wait_idle();
    chk("row 7e", 8'h11, nvmpe_flash_model_inst.peek({1'b0, 7'h01, 3'h0, 7'h7e}));
    chk("row 7f", 8'h22, nvmpe_flash_model_inst.peek({1'b0, 7'h01, 3'h0, 7'h7f}));
    rdc(8'hfb, 8'he0);
    $display("end row program");
    flash_divider = 8'h02; wr(8'hfe, 8'h00); wr(8'hff, 8'h04);
    repeat (3000) cyc(); rdc(8'hff, 8'h04);
    wait_idle(); flash_divider = 8'h01;
    chk("timeout irq", 8'h01, {7'h00, irq});
    rdc(8'hfb, 8'hc4);
    $display("end row timeout");
    wr(8'hfc, 8'h00); wr(8'hff, 8'h01);
    mem_wr = 1; repeat (2) cyc(); mem_wr = 0;
    chk("bulk wait", 8'h01, {7'h00, cpu_wait});
    wait_idle(); rdc(8'hfb, 8'he0);
    chk("bulk main", 8'hff, nvmpe_flash_model_inst.peek({1'b0, 7'h01, 3'h0, 7'h7e}));
    chk("bulk info", 8'hff, nvmpe_flash_model_inst.peek({1'b1, 7'h00, 3'h1, 7'h02}));
    $display("end mass erase");
    final_report();
  end
endmodule // nvm_program_erase_control_test
bind nvmpe_ctrl nvmpe_ctrl_monitor nvmpe_ctrl_monitor_inst (.clk, .rst_n, .clk_en, .io_addr,
  .io_wdata,
  .io_wr, .io_rd, .io_rdata, .data_wr, .mem_rd, .mem_wr, .block_protect, .cpu_wait,
  .arr_write, .arr_page_erase, .arr_bulk_erase, .arr_info, .arr_page);

// File: dv/nvmpe_ctrl_monitor.sv
`timescale 1ns/100ps
module nvmpe_ctrl_monitor
  import nvmpe_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input logic      [7:0] io_rdata,
  input wire logic       data_wr,
  input wire logic       mem_rd,
  input wire logic       mem_wr,
  input wire logic [7:0] block_protect,
  input logic            cpu_wait,
  input logic            arr_write,
  input logic            arr_page_erase,
  input logic            arr_bulk_erase,
  input logic            arr_info,
  input logic      [6:0] arr_page
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] page_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) page_q <= 8'h00;
    else if (clk_en && io_wr && io_addr == NVM_PAGE_SELECT_ADDR) page_q <= io_wdata;
  a_unmapped_zero: assert property (io_rd && io_addr < 8'hfb |-> ##1 io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_resv_zero: assert property (io_rd && io_addr == 8'hfb |-> ##1 !io_rdata[4])
    else $error("interrupt control bit 4 not zero");
  a_row_resv_zero: assert property (io_rd && io_addr == 8'hfd |-> ##1 io_rdata[7:3] == 5'h00)
    else $error("row select upper bits not zero");
  a_col_resv_zero: assert property (io_rd && io_addr == 8'hfe |-> ##1 !io_rdata[7])
    else $error("column select bit 7 not zero");
  a_write_blocked: assert property (data_wr && !page_q[7] && block_protect[page_q[6:4]]
    |=> !arr_write [*3])
    else $error("protected block written");
  a_write_target: assert property (arr_write |-> arr_info == page_q[7]
    && (arr_info || arr_page == page_q[6:0]))
    else $error("byte written to wrong page");
  a_bulk_refused: assert property (io_wr && io_addr == 8'hff && io_wdata[0] && |block_protect
    |=> !arr_bulk_erase [*3])
    else $error("mass erase with protection started");
  a_page_refused: assert property (io_wr && io_addr == 8'hff && io_wdata[1:0] == 2'b10
    && !page_q[7] && block_protect[page_q[6:4]] |=> !arr_page_erase [*3])
    else $error("protected page erase started");
  a_wait_cause: assert property ($rose(cpu_wait) |-> $past(mem_rd || mem_wr))
    else $error("wait raised without flash access");
  c_byte_write: cover property (arr_write);
  c_page_erase: cover property (arr_page_erase);
  c_bulk_erase: cover property (arr_bulk_erase);
endmodule // nvmpe_ctrl_monitor

// File: dv/nvmpe_flash_model.sv
`timescale 1ns/100ps
module nvmpe_flash_model
  import nvmpe_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arr_write,
  input  wire logic       arr_page_erase,
  input  wire logic       arr_bulk_erase,
  input  wire logic       arr_info,
  input  wire logic [6:0] arr_page,
  input  wire logic [2:0] arr_row,
  input  wire logic [6:0] arr_column,
  input  wire logic [7:0] arr_wdata
);
  logic [7:0] mem [0:262143];
  initial for (int i = 0; i < 262144; i++) mem[i] = 8'hff;
  function automatic logic [7:0] peek(input logic [17:0] a);
    return mem[a];
  endfunction
  always @(posedge clk)
  begin
    if (arr_write)
      mem[{arr_info, (arr_info ? 7'h00 : arr_page), arr_row, arr_column}] = arr_wdata;
    if (arr_page_erase)
      for (int i = 0; i < 1024; i++)
        mem[{arr_info, (arr_info ? 7'h00 : arr_page), i[9:0]}] = 8'hff;
    if (arr_bulk_erase)
      for (int i = 0; i < 262144; i++)
        if (!arr_info || i[17]) mem[i] = 8'hff;
  end
endmodule // nvmpe_flash_model

// File: src/nvmpe_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - separate done and error interrupt enables
// - successful operation sets done, may interrupt
// - row program aborts after 2432 ticks
// - protected block write dropped, violation flagged
// - protected page erase refused, flagged
// - mass erase with protection refused, flagged
// - any error flag interrupts when enabled
// - reading interrupt control clears flags
// - top page bit selects information page
// - page field picks one of 128
// - single byte written at page row column
// - row program increments column per byte
// - row program clears after the column 127 byte or timeout
// - mass erase clears itself when done
// - page erase clears itself when done
// - erase stalls all flash accesses
// - row program stalls flash reads
// - flash tick from programmable divider
// - any protection bit blocks mass erase
module nvmpe_ctrl
  import nvmpe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  flash_divider,
  input  wire logic [7:0]  block_protect,
  output logic             cpu_wait,
  output logic             irq,
  output logic             arr_write,
  output logic             arr_page_erase,
  output logic             arr_bulk_erase,
  output logic             arr_info,
  output logic      [6:0]  arr_page,
  output logic      [2:0]  arr_row,
  output logic      [6:0]  arr_column,
  output logic      [7:0]  arr_wdata
);
  nvmpe_state_e state;
  logic       done_irq_enable;
  logic       error_irq_enable;
  logic       done_flag;
  logic       write_violation_flag;
  logic       row_program_timeout_flag;
  logic       page_erase_violation_flag;
  logic       bulk_erase_violation_flag;
  logic [7:0] page_reg;
  logic [2:0] row_reg;
  logic [6:0] col_reg;
  logic [2:0] pgctl;
  logic [TICK_CNT_W-1:0] ticks;

  nvmpe_tick_if tk ();
  nvmpe_tick_gen u_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .tk     (tk)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire info_page_select = page_reg[INFO_PAGE_SELECT_BIT];
  // page to 16 KB block: 16 pages per block
  wire [2:0] page_block = page_reg[6:4];
  wire page_prot  = !info_page_select && block_protect[page_block];
  wire any_prot   = |block_protect;

  wire wr_irq = io_wr && hit(io_addr, NVM_INTERRUPT_CONTROL_ADDR);
  wire rd_irq = io_rd && hit(io_addr, NVM_INTERRUPT_CONTROL_ADDR);
  wire wr_pg  = io_wr && hit(io_addr, NVM_PAGE_SELECT_ADDR);
  wire wr_row = io_wr && hit(io_addr, NVM_ROW_SELECT_ADDR);
  wire wr_col = io_wr && hit(io_addr, NVM_COLUMN_SELECT_ADDR);
  wire wr_ctl = io_wr && hit(io_addr, NVM_PROGRAM_CONTROL_ADDR) && state == NVMPE_IDLE;

  wire start_bulk = wr_ctl && io_wdata[BULK_ERASE_GO_BIT];
  wire start_page = wr_ctl && !io_wdata[BULK_ERASE_GO_BIT] && io_wdata[PAGE_ERASE_GO_BIT];
  wire start_row  = wr_ctl && !io_wdata[BULK_ERASE_GO_BIT] && !io_wdata[PAGE_ERASE_GO_BIT]
                    && io_wdata[ROW_PROGRAM_GO_BIT];

  wire bulk_viol  = start_bulk && any_prot;
  wire page_viol  = start_page && page_prot;
  wire byte_wr    = data_wr && (state == NVMPE_IDLE || state == NVMPE_ROW_PROGRAM);
  wire wr_viol    = byte_wr && page_prot;
  wire byte_ok    = byte_wr && !page_prot;

  wire ticking    = tk.tick && state != NVMPE_IDLE;
  wire erase_end  = ticking && ((state == NVMPE_PAGE_ERASE
                      && ticks == TICK_CNT_W'(PAGE_ERASE_TICKS - 1))
                    || (state == NVMPE_BULK_ERASE
                      && ticks == TICK_CNT_W'(BULK_ERASE_TICKS - 1)));
  wire row_tmo    = ticking && state == NVMPE_ROW_PROGRAM
                    && ticks == TICK_CNT_W'(ROW_PROGRAM_TIMEOUT_TICKS - 1);
  wire row_last   = state == NVMPE_ROW_PROGRAM && byte_ok && col_reg == 7'h7f;
  wire row_end    = row_last && !row_tmo;
  wire op_done    = erase_end || row_end;

  wire erasing    = state == NVMPE_PAGE_ERASE || state == NVMPE_BULK_ERASE;
  wire next_wait  = (erasing && (mem_rd || mem_wr))
                    || (state == NVMPE_ROW_PROGRAM && mem_rd);

  wire [7:0] irq_reg = {done_irq_enable, error_irq_enable, done_flag, 1'b0,
                        write_violation_flag, row_program_timeout_flag,
                        page_erase_violation_flag, bulk_erase_violation_flag};
  wire any_err = write_violation_flag || row_program_timeout_flag
                 || page_erase_violation_flag || bulk_erase_violation_flag;
  wire next_irq = (done_irq_enable && done_flag)
                  || (error_irq_enable && any_err);

  wire [7:0] next_rdata =
      hit(io_addr, NVM_INTERRUPT_CONTROL_ADDR) ? irq_reg :
      hit(io_addr, NVM_PAGE_SELECT_ADDR)       ? page_reg :
      hit(io_addr, NVM_ROW_SELECT_ADDR)        ? {5'h00, row_reg} :
      hit(io_addr, NVM_COLUMN_SELECT_ADDR)     ? {1'b0, col_reg} :
      hit(io_addr, NVM_PROGRAM_CONTROL_ADDR)   ? {5'h00, pgctl} : 8'h00;

  assign tk.start   = start_bulk || start_page || start_row;
  assign tk.divider = flash_divider;

  // sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= NVMPE_IDLE;
      ticks <= '0;
      pgctl <= NVM_PROGRAM_CONTROL_RST;
    end
    else if (clk_en)
    begin
      unique case (state)
        NVMPE_IDLE:
        begin
          ticks <= '0;
          if (start_bulk && !bulk_viol)
          begin
            state <= NVMPE_BULK_ERASE;
            pgctl <= 3'h1;
          end
          else if (start_page && !page_viol)
          begin
            state <= NVMPE_PAGE_ERASE;
            pgctl <= 3'h2;
          end
          else if (start_row)
          begin
            state <= NVMPE_ROW_PROGRAM;
            pgctl <= 3'h4;
          end
        end
        NVMPE_PAGE_ERASE, NVMPE_BULK_ERASE, NVMPE_ROW_PROGRAM:
        begin
          if (ticking)
            ticks <= ticks + TICK_CNT_W'(1);
          if (erase_end || row_tmo || row_end)
          begin
            state <= NVMPE_IDLE;
            pgctl <= 3'h0;
          end
        end
      endcase
    end
  end

  // interrupt control, set beats read clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_irq_enable           <= NVM_INTERRUPT_CONTROL_RST[DONE_IRQ_ENABLE_BIT];
      error_irq_enable          <= NVM_INTERRUPT_CONTROL_RST[ERROR_IRQ_ENABLE_BIT];
      done_flag                 <= 1'b0;
      write_violation_flag      <= 1'b0;
      row_program_timeout_flag  <= 1'b0;
      page_erase_violation_flag <= 1'b0;
      bulk_erase_violation_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_irq)
      begin
        done_irq_enable  <= io_wdata[DONE_IRQ_ENABLE_BIT];
        error_irq_enable <= io_wdata[ERROR_IRQ_ENABLE_BIT];
      end
      done_flag <= op_done || (done_flag && !rd_irq);
      write_violation_flag      <= wr_viol || (write_violation_flag && !rd_irq);
      row_program_timeout_flag  <= row_tmo || (row_program_timeout_flag && !rd_irq);
      page_erase_violation_flag <= page_viol || (page_erase_violation_flag && !rd_irq);
      bulk_erase_violation_flag <= bulk_viol || (bulk_erase_violation_flag && !rd_irq);
    end
  end

  // address registers; column walks during row program
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_reg <= NVM_PAGE_SELECT_RST;
      row_reg  <= NVM_ROW_SELECT_RST;
      col_reg  <= NVM_COLUMN_SELECT_RST;
    end
    else if (clk_en)
    begin
      if (wr_pg)
        page_reg <= io_wdata;
      if (wr_row)
        row_reg <= io_wdata[2:0];
      if (wr_col)
        col_reg <= io_wdata[6:0];
      else if (state == NVMPE_ROW_PROGRAM && byte_ok)
        col_reg <= col_reg + 7'h01;
    end
  end

  // registered outputs to array and cpu
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rdata       <= 8'h00;
      cpu_wait       <= 1'b0;
      irq            <= 1'b0;
      arr_write      <= 1'b0;
      arr_page_erase <= 1'b0;
      arr_bulk_erase <= 1'b0;
      arr_info       <= 1'b0;
      arr_page       <= 7'h00;
      arr_row        <= 3'h0;
      arr_column     <= 7'h00;
      arr_wdata      <= 8'h00;
    end
    else if (clk_en)
    begin
      if (io_rd)
        io_rdata <= next_rdata;
      cpu_wait       <= next_wait;
      irq            <= next_irq;
      arr_write      <= byte_ok;
      arr_page_erase <= start_page && !page_viol;
      arr_bulk_erase <= start_bulk && !bulk_viol;
      arr_info       <= info_page_select;
      arr_page       <= page_reg[6:0];
      arr_row        <= row_reg;
      arr_column     <= col_reg;
      arr_wdata      <= data_wdata;
    end
  end
endmodule // nvmpe_ctrl

// File: src/nvmpe_pkg.sv
package nvmpe_pkg;

  localparam logic [7:0] NVM_INTERRUPT_CONTROL_ADDR = 8'hfb;
  localparam logic [7:0] NVM_PAGE_SELECT_ADDR       = 8'hfc;
  localparam logic [7:0] NVM_ROW_SELECT_ADDR        = 8'hfd;
  localparam logic [7:0] NVM_COLUMN_SELECT_ADDR     = 8'hfe;
  localparam logic [7:0] NVM_PROGRAM_CONTROL_ADDR   = 8'hff;

  localparam logic [7:0] NVM_INTERRUPT_CONTROL_RST  = 8'h00;
  localparam logic [7:0] NVM_PAGE_SELECT_RST        = 8'h00;
  localparam logic [2:0] NVM_ROW_SELECT_RST         = 3'h0;
  localparam logic [6:0] NVM_COLUMN_SELECT_RST      = 7'h00;
  localparam logic [2:0] NVM_PROGRAM_CONTROL_RST    = 3'h0;

  // interrupt control fields
  localparam int DONE_IRQ_ENABLE_BIT     = 7;
  localparam int ERROR_IRQ_ENABLE_BIT    = 6;
  localparam int DONE_FLAG_BIT           = 5;
  localparam int WRITE_VIOLATION_BIT     = 3;
  localparam int ROW_PROGRAM_TIMEOUT_BIT = 2;
  localparam int PAGE_ERASE_VIOL_BIT     = 1;
  localparam int BULK_ERASE_VIOL_BIT     = 0;

  // program control fields
  localparam int ROW_PROGRAM_GO_BIT  = 2;
  localparam int PAGE_ERASE_GO_BIT   = 1;
  localparam int BULK_ERASE_GO_BIT   = 0;

  localparam int INFO_PAGE_SELECT_BIT = 7;

  // timing in flash controller clock periods (5.1..6.5 us each)
  localparam int ROW_PROGRAM_TIMEOUT_TICKS = 2432;
  localparam real PAGE_ERASE_TIME_MS       = 10.0;
  localparam real BULK_ERASE_TIME_MS       = 200.0;
  localparam real FLASH_TICK_MAX_US        = 6.5;
  localparam int PAGE_ERASE_TICKS =
    int'(PAGE_ERASE_TIME_MS * 1000.0 / FLASH_TICK_MAX_US);
  localparam int BULK_ERASE_TICKS =
    int'(BULK_ERASE_TIME_MS * 1000.0 / FLASH_TICK_MAX_US);
  localparam int TICK_CNT_W = 16;

  localparam logic [7:0] FLASH_DIVIDER_RST = 8'h01;
  localparam logic [7:0] ROW_BYTES         = 8'h80;

  typedef enum logic [1:0] {
    NVMPE_IDLE,
    NVMPE_PAGE_ERASE,
    NVMPE_BULK_ERASE,
    NVMPE_ROW_PROGRAM
  } nvmpe_state_e;

endpackage

// File: src/nvmpe_tick_gen.sv
`timescale 1ns/100ps
module nvmpe_tick_gen
  import nvmpe_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  nvmpe_tick_if.gen   tk
);
  logic [7:0] count;
  wire        wrap = (count >= tk.divider - 8'h01) || (tk.divider == 8'h00);

  // flash controller clock as a tick every divider system cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count   <= 8'h00;
      tk.tick <= 1'b0;
    end
    else if (clk_en)
    begin
      count   <= (tk.start || wrap) ? 8'h00 : count + 8'h01;
      tk.tick <= wrap && !tk.start;
    end
  end
endmodule // nvmpe_tick_gen

// File: src/nvmpe_tick_if.sv
`timescale 1ns/100ps
interface nvmpe_tick_if;
  logic       start;
  logic [7:0] divider;
  logic       tick;
  modport gen  (input start, input divider, output tick);
  modport user (output start, output divider, input tick);
endinterface
